// ==== rtl/monitor_regs_pkg.sv ====
package monitor_regs_pkg;

  // register offsets on the management bus
  localparam logic [6:0] ADDR_MASK_ONE = 7'h43;
  localparam logic [6:0] ADDR_MASK_TWO = 7'h44;
  localparam logic [6:0] ADDR_SPARE = 7'h45;
  localparam logic [6:0] ADDR_INTR_CLR = 7'h46;
  localparam logic [6:0] ADDR_FAN_DIV = 7'h47;
  localparam logic [6:0] ADDR_SLAVE = 7'h48;
  localparam logic [6:0] ADDR_IDENT4 = 7'h49;
  localparam logic [6:0] ADDR_TEMP_CFG = 7'h4B;

  // power-on values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [6:0] RST_INTR_CLR_LO = 7'h00;
  localparam logic [3:0] RST_FAN_DIV = 4'h5;
  localparam logic [4:0] RST_ADDR_HI = 5'h0B;
  localparam logic RST_ADDR_B7 = 1'b0;
  localparam logic [6:0] RST_IDENT4_HI = 7'h00;
  localparam logic [6:0] RST_TEMP_CFG_LO = 7'h01;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // field positions
  localparam int RESET_EN_BIT = 7;
  localparam int INTR_CLR_BIT = 7;
  localparam int INTR_STATUS_BIT = 4;
  localparam int TEMP_HALF_BIT = 7;

  // mask bits that gate a real status bit
  localparam logic [7:0] IMPL_MASK_ONE = 8'hDF;
  localparam logic [7:0] IMPL_MASK_TWO = 8'h13;

  // pulse timing on the reset and intrusion pins
  localparam int PULSE_MS = 20;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int PULSE_CYCLES_DEF = (PULSE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {
    TEMP_REPEAT = 2'h0,
    TEMP_ONCE = 2'h1,
    TEMP_COMPARE = 2'h3
  } temp_mode_t;

  // both 00 and 11 select repetitive mode
  function automatic temp_mode_t tempModeOf(input logic [1:0] sel);
    case (sel)
      2'h1: tempModeOf = TEMP_ONCE;
      2'h2: tempModeOf = TEMP_COMPARE;
      default: tempModeOf = TEMP_REPEAT;
    endcase
  endfunction

  // 00 -> 1, 01 -> 2, 10 -> 4, 11 -> 8
  function automatic logic [3:0] divisorOf(input logic [1:0] sel);
    divisorOf = 4'h1 << sel;
  endfunction

endpackage

// ==== rtl/pulse_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface pulse_if;
  logic start;
  logic active;
  logic done;
  modport timer (input start, output active, output done);
  modport ctrl (output start, input active, input done);
endinterface
`default_nettype wire

// ==== rtl/pulse_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module pulse_timer
  import monitor_regs_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYCLES_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // request and pulse
  pulse_if.timer pulse
);

  typedef enum logic {T_IDLE = 1'b0, T_RUN = 1'b1} timer_state_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  timer_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic lastTick;

  assign lastTick = (state_q == T_RUN) && (cnt_q == LAST);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      T_IDLE: begin
        cnt_d = CNT_ZERO;
        if (pulse.start) begin
          state_d = T_RUN;
        end
      end
      T_RUN: begin
        // a new start while running is absorbed, never stretches the pulse
        cnt_d = cnt_q + CNT_ONE;
        if (lastTick) begin
          state_d = T_IDLE;
        end
      end
      default: state_d = T_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= T_IDLE;
      cnt_q <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign pulse.active = (state_q == T_RUN);
  assign pulse.done = lastTick;

  // helper: length of the current pulse
  logic [CNT_W-1:0] runLen_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      runLen_q <= CNT_ZERO;
    end else if (pulse.active) begin
      runLen_q <= runLen_q + CNT_ONE;
    end else begin
      runLen_q <= CNT_ZERO;
    end
  end

  pulse_length_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(pulse.active) |-> (runLen_q == CNT_W'(PULSE_CYCLES)))
    else $error("pulse ended at the wrong length");

  pulse_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!pulse.active && pulse.start) |=> pulse.active)
    else $error("start did not open a pulse");

endmodule // pulse_timer
`default_nettype wire

// ==== rtl/monitor_mask_config.sv ====
`timescale 1ns/100ps
`default_nettype none
module monitor_mask_config
  import monitor_regs_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYCLES_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register access from the serial bus engine
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // configuration register side
  input wire logic cfgResetReq,
  input wire logic cfgIntrusionReq,
  input wire logic initReq,
  input wire logic alarmEnable,
  output logic cfgResetBit,
  output logic cfgIntrusionBit,
  // interrupt status
  input wire logic [7:0] statusOne,
  input wire logic [7:0] statusTwo,
  input wire logic intrusionStatusClr,
  output logic intrusionStatus,
  output logic alarmIntN,
  // chassis intrusion pin
  input wire logic chassisIntrusionIn,
  output logic chassisIntrusionOut,
  output logic chassisIntrusionOe,
  // reset output
  output logic resetOutN,
  // identification, straps and temperature
  input wire logic [4:0] voltageIdentInputs,
  input wire logic addrStrapHi,
  input wire logic addrStrapLo,
  input wire logic tempHalfLsb,
  // decoded settings
  output logic [3:0] tachOneDivisor,
  output logic [3:0] tachTwoDivisor,
  output logic [6:0] slaveAddress,
  output temp_mode_t tempIntMode
);

  // write decode
  wire wrMaskOne = regWrEn && (regAddr == ADDR_MASK_ONE);
  wire wrMaskTwo = regWrEn && (regAddr == ADDR_MASK_TWO);
  wire wrSpare = regWrEn && (regAddr == ADDR_SPARE);
  wire wrIntrClr = regWrEn && (regAddr == ADDR_INTR_CLR);
  wire wrFanDiv = regWrEn && (regAddr == ADDR_FAN_DIV);
  wire wrSlave = regWrEn && (regAddr == ADDR_SLAVE);
  wire wrIdent4 = regWrEn && (regAddr == ADDR_IDENT4);
  wire wrTempCfg = regWrEn && (regAddr == ADDR_TEMP_CFG);

  logic [7:0] maskOne_q;
  logic [7:0] maskTwo_q;
  logic [7:0] spare_q;
  logic [6:0] intrClrLo_q;
  logic [3:0] fanDiv_q;
  logic [4:0] addrHi_q;
  logic addrB7_q;
  logic [6:0] ident4Hi_q;
  logic [6:0] tempCfgLo_q;
  logic intrStatus_q;
  logic alarmIntN_q;
  logic [7:0] rdData_q;

  // pulse timers for the reset and intrusion pins
  pulse_if resetPulse();
  pulse_if intrPulse();

  pulse_timer #(.PULSE_CYCLES(PULSE_CYCLES)) resetTimer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pulse(resetPulse.timer)
  );

  pulse_timer #(.PULSE_CYCLES(PULSE_CYCLES)) intrTimer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pulse(intrPulse.timer)
  );

  wire resetEnable = maskTwo_q[RESET_EN_BIT];
  // request dropped, not queued, while the enable is low
  assign resetPulse.start = cfgResetReq && resetEnable;
  // either location starts the same pulse
  wire intrWriteOne = wrIntrClr && regWrData[INTR_CLR_BIT];
  assign intrPulse.start = intrWriteOne || cfgIntrusionReq;

  // control bits read as one exactly while their pulse runs
  wire intrClrBit = intrPulse.active;
  assign cfgIntrusionBit = intrClrBit;
  assign cfgResetBit = resetPulse.active;
  assign resetOutN = !resetPulse.active;
  assign chassisIntrusionOut = 1'b0;
  assign chassisIntrusionOe = intrPulse.active;

  // status set wins over a clear in the same cycle
  wire intrStatus_d = chassisIntrusionIn || (intrStatus_q && !intrusionStatusClr);
  assign intrusionStatus = intrStatus_q;

  // alarm gating
  wire [7:0] statusTwoAll = {statusTwo[7:INTR_STATUS_BIT+1], intrStatus_q,
                             statusTwo[INTR_STATUS_BIT-1:0]};
  wire [7:0] pendOne = statusOne & ~maskOne_q & IMPL_MASK_ONE;
  wire [7:0] pendTwo = statusTwoAll & ~maskTwo_q & IMPL_MASK_TWO;
  wire alarmAny = alarmEnable && ((|pendOne) || (|pendTwo));
  assign alarmIntN = alarmIntN_q;

  // register storage; init restores power-on values except 45h and 48h
  always_ff @(posedge sys_clk) begin
    if (!resetn || initReq) begin
      maskOne_q <= RST_MASK;
      maskTwo_q <= RST_MASK;
      intrClrLo_q <= RST_INTR_CLR_LO;
      fanDiv_q <= RST_FAN_DIV;
      ident4Hi_q <= RST_IDENT4_HI;
      tempCfgLo_q <= RST_TEMP_CFG_LO;
    end else begin
      if (wrMaskOne) begin
        maskOne_q <= regWrData;
      end
      if (wrMaskTwo) begin
        maskTwo_q <= regWrData;
      end
      if (wrIntrClr) begin
        intrClrLo_q <= regWrData[INTR_CLR_BIT-1:0];
      end
      if (wrFanDiv) begin
        fanDiv_q <= regWrData[7:4];
      end
      if (wrIdent4) begin
        ident4Hi_q <= regWrData[7:1];
      end
      if (wrTempCfg) begin
        tempCfgLo_q <= regWrData[6:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      spare_q <= RST_SPARE;
      addrHi_q <= RST_ADDR_HI;
      addrB7_q <= RST_ADDR_B7;
    end else begin
      if (wrSpare) begin
        spare_q <= regWrData;
      end
      if (wrSlave) begin
        addrHi_q <= regWrData[6:2];
        addrB7_q <= regWrData[7];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      intrStatus_q <= 1'b0;
      alarmIntN_q <= 1'b1;
    end else begin
      intrStatus_q <= intrStatus_d;
      alarmIntN_q <= !alarmAny;
    end
  end

  // read selection; live inputs are sampled into the read register
  wire [7:0] rdFanDiv = {fanDiv_q, voltageIdentInputs[3:0]};
  wire [7:0] rdSlave = {addrB7_q, addrHi_q, addrStrapHi, addrStrapLo};
  wire [7:0] rdIdent4 = {ident4Hi_q, voltageIdentInputs[4]};
  wire [7:0] rdTempCfg = {tempHalfLsb, tempCfgLo_q};
  wire [7:0] rdIntrClr = {intrClrBit, intrClrLo_q};
  wire [7:0] rdSel =
    (regAddr == ADDR_MASK_ONE) ? maskOne_q :
    (regAddr == ADDR_MASK_TWO) ? maskTwo_q :
    (regAddr == ADDR_SPARE) ? spare_q :
    (regAddr == ADDR_INTR_CLR) ? rdIntrClr :
    (regAddr == ADDR_FAN_DIV) ? rdFanDiv :
    (regAddr == ADDR_SLAVE) ? rdSlave :
    (regAddr == ADDR_IDENT4) ? rdIdent4 :
    (regAddr == ADDR_TEMP_CFG) ? rdTempCfg : READ_UNMAPPED;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdData_q <= READ_UNMAPPED;
    end else if (regRdEn) begin
      rdData_q <= rdSel;
    end
  end
  assign regRdData = rdData_q;

  // decoded settings; flops keep the outputs glitch free
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tachOneDivisor <= divisorOf(RST_FAN_DIV[1:0]);
      tachTwoDivisor <= divisorOf(RST_FAN_DIV[3:2]);
      slaveAddress <= {RST_ADDR_HI, 2'h0};
      tempIntMode <= tempModeOf(RST_TEMP_CFG_LO[1:0]);
    end else begin
      tachOneDivisor <= divisorOf(fanDiv_q[1:0]);
      tachTwoDivisor <= divisorOf(fanDiv_q[3:2]);
      slaveAddress <= {addrHi_q, addrStrapHi, addrStrapLo};
      tempIntMode <= tempModeOf(tempCfgLo_q[1:0]);
    end
  end

  mask_blocks_alarm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((statusOne & IMPL_MASK_ONE & ~maskOne_q) == 8'h00 &&
     (statusTwoAll & IMPL_MASK_TWO & ~maskTwo_q) == 8'h00) |=> alarmIntN)
    else $error("masked status reached the alarm output");

  alarm_raise_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (alarmEnable && (|pendOne)) |=> !alarmIntN)
    else $error("unmasked status did not raise the alarm");

  reset_ignored_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cfgResetReq && !resetEnable && !resetPulse.active) |=> resetOutN)
    else $error("reset pulse without enable");

  reset_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cfgResetReq && resetEnable && resetOutN) |=> (!resetOutN && cfgResetBit)[*8])
    else $error("reset pulse did not start or hold");

  intr_pin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (intrWriteOne && !chassisIntrusionOe) |=> (chassisIntrusionOe && intrClrBit)[*4])
    else $error("intrusion pulse not driven");

  intr_status_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    chassisIntrusionIn |=> intrusionStatus)
    else $error("intrusion status lost while input high");

  spare_store_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrSpare |=> (spare_q == $past(regWrData)))
    else $error("spare byte did not store write");

  strap_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_SLAVE) |=> (regRdData[1:0] == $past({addrStrapHi, addrStrapLo})))
    else $error("address bits do not follow straps");

  temp_half_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_TEMP_CFG) |=> (regRdData[TEMP_HALF_BIT] == $past(tempHalfLsb)))
    else $error("temperature half bit wrong");

  fan_div_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrFanDiv |=> ##1 (tachOneDivisor == divisorOf($past(regWrData[5:4], 2))))
    else $error("first divisor not taken from write");

  tach_two_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrFanDiv |=> ##1 (tachTwoDivisor == divisorOf($past(regWrData[7:6], 2))))
    else $error("second divisor not taken from write");

  fan_ident_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_FAN_DIV) |=>
      (regRdData[3:0] == $past(voltageIdentInputs[3:0])))
    else $error("divisor low nibble does not follow ident inputs");

  ident_four_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_IDENT4) |=> (regRdData[0] == $past(voltageIdentInputs[4])))
    else $error("ident bit four not read back");

  slave_upper_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrSlave |=> ##1 (slaveAddress[6:2] == $past(regWrData[6:2], 2)))
    else $error("slave address upper bits not taken from write");

  temp_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrTempCfg |=> ##1 (tempIntMode == tempModeOf($past(regWrData[1:0], 2))))
    else $error("temperature mode not taken from write");

  reset_enable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(resetOutN) |-> $past(resetEnable))
    else $error("reset pulse began without enable");

  clear_bit_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_INTR_CLR && !intrPulse.active) |=>
      !regRdData[INTR_CLR_BIT])
    else $error("clear bit read as one with no pulse running");

  mirror_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (intrWriteOne && !intrPulse.active) |=> cfgIntrusionBit)
    else $error("clear write not mirrored into configuration bit");

  status_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (intrusionStatusClr && !chassisIntrusionIn) |=> !intrusionStatus)
    else $error("intrusion status not cleared");

  spare_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_SPARE) |=> (regRdData == $past(spare_q)))
    else $error("spare byte not read back");

endmodule // monitor_mask_config
`default_nettype wire

// ==== test/bus_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bus_host_model (
  // clock
  input wire logic sys_clk,
  // register bus
  output logic [6:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 7'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // strobes last one cycle; released data flips so stale values never match
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
endmodule // bus_host_model
`default_nettype wire

// ==== test/monitor_mask_config_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module monitor_mask_config_bench;
  import monitor_regs_pkg::*;
  localparam int PULSE_N = 16;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] regAddr;
  logic regWrEn, regRdEn;
  logic [7:0] regWrData, regRdData, statusOne, statusTwo, rd;
  logic cfgResetReq, cfgIntrusionReq, alarmEnable, cfgResetBit, cfgIntrusionBit;
  logic intrusionStatusClr, intrusionStatus, alarmIntN, intrPin, resetOutN;
  logic chassisIntrusionIn, chassisIntrusionOut, chassisIntrusionOe;
  logic [4:0] voltage_ident_inputs;
  logic strapHi, strapLo, half;
  logic [3:0] tachOneDivisor, tachTwoDivisor;
  logic [6:0] slaveAddress;
  temp_mode_t tempIntMode;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h1575;
  int shadow [int];
  int addrs [9] = '{'h43, 'h44, 'h45, 'h46, 'h47, 'h48, 'h49, 'h4A, 'h4B};
  int n, b, d;
  // open-drain pin: low while the device drives it, else the outside level
  assign chassisIntrusionIn = chassisIntrusionOe ? chassisIntrusionOut : intrPin;
  always #10 sys_clk = ~sys_clk;
  monitor_mask_config #(.PULSE_CYCLES(PULSE_N)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .cfgResetReq(cfgResetReq), .cfgIntrusionReq(cfgIntrusionReq),
    .initReq(1'b0), .alarmEnable(alarmEnable), .cfgResetBit(cfgResetBit),
    .cfgIntrusionBit(cfgIntrusionBit), .statusOne(statusOne), .statusTwo(statusTwo),
    .intrusionStatusClr(intrusionStatusClr), .intrusionStatus(intrusionStatus),
    .alarmIntN(alarmIntN), .chassisIntrusionIn(chassisIntrusionIn),
    .chassisIntrusionOut(chassisIntrusionOut), .chassisIntrusionOe(chassisIntrusionOe),
    .resetOutN(resetOutN), .voltageIdentInputs(voltage_ident_inputs), .addrStrapHi(strapHi),
    .addrStrapLo(strapLo), .tempHalfLsb(half), .tachOneDivisor(tachOneDivisor),
    .tachTwoDivisor(tachTwoDivisor), .slaveAddress(slaveAddress), .tempIntMode(tempIntMode));
  bus_host_model host_u (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [7:0] expRd(input int a);
    logic [7:0] s;
    s = shadow.exists(a) ? 8'(shadow[a]) : 8'h00;
    case (a)
      'h47: expRd = {s[7:4], voltage_ident_inputs[3:0]};
      'h48: expRd = {s[7:2], strapHi, strapLo};
      'h49: expRd = {s[7:1], voltage_ident_inputs[4]};
      'h4B: expRd = {half, s[6:0]};
      default: expRd = s;
    endcase
  endfunction
  function automatic logic expAlarm(input logic st);
    logic [7:0] m1, m2;
    m1 = 8'(shadow['h43]);
    m2 = 8'(shadow['h44]);
    expAlarm = !(alarmEnable && ((|(statusOne & ~m1 & IMPL_MASK_ONE)) ||
      (|(statusTwo & ~m2 & IMPL_MASK_TWO & 8'hEF)) || (st && !m2[INTR_STATUS_BIT])));
  endfunction
  task automatic wr(input int a, input int v);
    host_u.wr(7'(a), 8'(v));
    // the clear bit reads back zero once its pulse is over
    if (shadow.exists(a)) shadow[a] = (a == 'h46) ? (v & 'h7F) : (v & 'hFF);
  endtask
  task automatic rdChk(input int a);
    host_u.rd(7'(a), rd);
    chk($sformatf("reg %h", a), expRd(a), rd);
  endtask
  // which: 0 reset request, 1 intrusion request, 2 clear write on the bus
  task automatic fire(input int which);
    n = 0;
    b = 0;
    if (which == 2) begin
      wr('h46, 'h80);
    end else begin
      @(negedge sys_clk);
      cfgResetReq = (which == 0);
      cfgIntrusionReq = (which == 1);
      @(negedge sys_clk);
      cfgResetReq = 1'b0;
      cfgIntrusionReq = 1'b0;
    end
    // first sample falls in the cycle right after the taking edge
    repeat (40) begin
      n += (which == 0) ? int'(!resetOutN) : int'(chassisIntrusionOe);
      b += (which == 0) ? int'(cfgResetBit) : (which == 1) ? int'(cfgIntrusionBit) :
        int'(chassisIntrusionOe && !chassisIntrusionOut);
      @(negedge sys_clk);
    end
  endtask
  // about 450 cycles of traffic; allow over twenty times that
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    intrPin = 1'b0;
    statusOne = 8'h00;
    statusTwo = 8'h00;
    cfgResetReq = 1'b0;
    cfgIntrusionReq = 1'b0;
    alarmEnable = 1'b0;
    intrusionStatusClr = 1'b0;
    voltage_ident_inputs = 5'($random(seed));
    strapHi = 1'($random(seed));
    strapLo = 1'($random(seed));
    half = 1'($random(seed));
    shadow = '{'h43: 0, 'h44: 0, 'h45: 0, 'h46: 0, 'h47: 'h50, 'h48: 'h2C, 'h49: 0, 'h4B: 1};
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    foreach (addrs[k]) rdChk(addrs[k]);
    chk("tachOne", 8'h02, 8'(tachOneDivisor));
    chk("tachTwo", 8'h02, 8'(tachTwoDivisor));
    chk("mode", 8'(TEMP_ONCE), 8'(tempIntMode));
    for (int i = 0; i < 4; i++) begin
      foreach (addrs[k]) begin
        d = $random(seed) & 'hFF;
        if (addrs[k] == 'h47) d = (d & 'h0F) | ((3 - i) << 6) | (i << 4);
        if (addrs[k] == 'h4B) d = (d & 'hFC) | i;
        if (addrs[k] == 'h46) d = d & 'h7F;
        wr(addrs[k], d);
      end
      foreach (addrs[k]) rdChk(addrs[k]);
      chk("tachOne", 8'(1 << i), 8'(tachOneDivisor));
      chk("tachTwo", 8'(1 << (3 - i)), 8'(tachTwoDivisor));
      chk("slave", expRd('h48) & 8'h7F, {1'b0, slaveAddress});
      d = (i == 1) ? int'(TEMP_ONCE) : (i == 2) ? int'(TEMP_COMPARE) : int'(TEMP_REPEAT);
      chk("mode", 8'(d), 8'(tempIntMode));
    end
    repeat (12) begin
      wr('h43, $random(seed));
      wr('h44, $random(seed) & 'h7F);
      @(negedge sys_clk);
      statusOne = 8'($random(seed) & $random(seed) & $random(seed));
      statusTwo = 8'($random(seed) & $random(seed));
      alarmEnable = 1'($random(seed) | $random(seed));
      @(negedge sys_clk);
      chk("alarm", 8'(expAlarm(1'b0)), 8'(alarmIntN));
    end
    statusOne = 8'h00;
    statusTwo = 8'h00;
    alarmEnable = 1'b1;
    wr('h44, 'h00);
    intrPin = 1'b1;
    @(negedge sys_clk);
    intrPin = 1'b0;
    @(negedge sys_clk);
    chk("intrusion", 8'h01, 8'(intrusionStatus));
    chk("alarm", 8'(expAlarm(1'b1)), 8'(alarmIntN));
    wr('h44, 'h10);
    @(negedge sys_clk);
    chk("alarm", 8'(expAlarm(1'b1)), 8'(alarmIntN));
    intrusionStatusClr = 1'b1;
    @(negedge sys_clk);
    intrusionStatusClr = 1'b0;
    @(negedge sys_clk);
    chk("intrusion", 8'h00, 8'(intrusionStatus));
    fire(0);
    chk("resetLow", 8'h00, 8'(n));
    wr('h44, 'h80);
    fire(0);
    chk("resetLow", 8'(PULSE_N), 8'(n));
    chk("resetBit", 8'(PULSE_N), 8'(b));
    fire(2);
    chk("pinLow", 8'(PULSE_N), 8'(n));
    chk("pinDrive", 8'(PULSE_N), 8'(b));
    rdChk('h46);
    wr('h46, 'h80);
    host_u.rd(ADDR_INTR_CLR, rd);
    chk("clrBit", 8'h80 | expRd('h46), rd);
    chk("mirror", 8'h01, 8'(cfgIntrusionBit));
    repeat (20) @(negedge sys_clk);
    fire(1);
    chk("pinLow", 8'(PULSE_N), 8'(n));
    chk("mirror", 8'(PULSE_N), 8'(b));
    chk("mirror", 8'h00, 8'(cfgIntrusionBit));
    wrap_up();
  end
endmodule // monitor_mask_config_bench
`default_nettype wire
